// ===== src/fmm_pkg.sv
// Package: opcodes, field layout, mask bit positions and reset values
package fmm_pkg;
    // ****************************************
    // Instruction word layout
    // ****************************************
    localparam int INSTR_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 4;
    localparam int IMM_W = 8;
    localparam int MASK_W = 8;
    // Prefixes: acc move uses top 9 bits, carry move the top 9 bits,
    // mask loads the top 8 bits.
    localparam logic [8:0] OP_LD_ACC = 9'h09d;
    localparam logic [8:0] OP_LD_CF = 9'h0b0;
    localparam logic [7:0] OP_LD_HOLD = 8'h43;
    localparam logic [7:0] OP_LD_INT = 8'h51;
    // ****************************************
    // Mask bit positions
    // ****************************************
    localparam int BIT_DIV0 = 0;
    localparam int BIT_TMR0 = 1;
    localparam int BIT_CHG = 2;
    localparam int BIT_RSVD = 3;
    localparam int BIT_EXT = 4;
    localparam int BIT_RX = 5;
    localparam int BIT_TX = 6;
    localparam int BIT_TMR1 = 7;
    // Reserved position always held at zero
    localparam logic [7:0] MASK_VALID = 8'hf7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [3:0] ACC_RESET = 4'h0;
    typedef enum logic [2:0] {
        FMM_NOP,
        FMM_LD_ACC,
        FMM_LD_CF,
        FMM_LD_HOLD,
        FMM_LD_INT
    } fmm_op_t;
endpackage

// ===== src/fmm_if.sv
// Interface: decoded instruction passed from decoder to executor
`timescale 1ns/1ns
interface fmm_dec_if;
    import fmm_pkg::*;
    fmm_op_t op;
    logic [6:0] addr;
    logic [7:0] imm;
    modport dec (output op, output addr, output imm);
    modport exe (input op, input addr, input imm);
endinterface

// ===== src/fmm_decode.sv
// Decoder: recognises the two move instructions and the two mask loads by opcode prefix
`timescale 1ns/1ns
module fmm_decode
    import fmm_pkg::*;
(
    // Instruction
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    // Decoded
    fmm_dec_if.dec dec
);
    always_comb begin
        dec.addr = instr_i[6:0];
        dec.imm = instr_i[7:0];
        dec.op = FMM_NOP;
        if (instr_valid_i) begin
            if (instr_i[15:7] == OP_LD_ACC) begin
                dec.op = FMM_LD_ACC; // [RULE12]
            end else if (instr_i[15:7] == OP_LD_CF) begin
                dec.op = FMM_LD_CF; // [RULE12]
            end else if (instr_i[15:8] == OP_LD_HOLD) begin
                dec.op = FMM_LD_HOLD; // [RULE12]
            end else if (instr_i[15:8] == OP_LD_INT) begin
                dec.op = FMM_LD_INT; // [RULE12]
            end
        end
    end
endmodule

// ===== src/fmm_core.sv
// Top: execution of memory moves and mask loads, event gating
`timescale 1ns/1ns
// Operation
// RULE1 - Memory-to-accumulator move loads 4-bit word, updates zero flag, one cycle
// RULE2 - Memory-bit-to-carry move loads word bit 0 into carry only
// RULE3 - Hold-release mask load writes all eight immediate bits, one cycle; the code writes bits 7..4 and 2..0 and forces bit 3 to zero
// RULE4 - Hold mask bits 0,1,7 let divider, timer0, timer1 end hold
// RULE5 - Hold mask bits 2,4 let port change, pin falling edge end hold
// RULE6 - Hold mask bits 5,6 let serial receive, transmit end hold
// RULE7 - Interrupt mask load sets or clears each enable bit, one cycle
// RULE8 - Interrupts 0,1,7 accepted only while enabled
// RULE9 - Interrupts 2,4 accepted only while enabled
// RULE10 - Interrupts 5,6 accepted only while enabled
// RULE11 - Bit 3 of both masks is reserved, ignored, gates nothing
// RULE12 - Instructions recognised by fixed opcode prefix, low bits are operand
module fmm_core
    import fmm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Instruction fetch
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    // Data memory read port
    output logic [6:0] mem_addr_o,
    input wire logic [3:0] mem_rdata_i,
    // Event sources, one-cycle pulses, bit 3 unused
    input wire logic [7:0] event_i,
    // Core state
    output logic [3:0] acc_o,
    output logic zero_flag_o,
    output logic carry_flag_o,
    output logic [7:0] hold_release_enable_mask_o,
    output logic [7:0] interrupt_enable_mask_o,
    // Gated events
    output logic hold_release_o,
    output logic [7:0] irq_accept_o
);
    // ****************************************
    // Decode
    // ****************************************
    fmm_dec_if dif ();

    fmm_decode u_dec (
        .instr_i(instr_i),
        .instr_valid_i(instr_valid_i),
        .dec(dif.dec)
    );

    // Memory read is combinational, so each move completes in one cycle
    assign mem_addr_o = dif.addr; // [RULE12]

    // ****************************************
    // Execute
    // ****************************************
    logic [3:0] acc;
    logic zero_flag;
    logic carry_flag;
    logic [7:0] hold_mask;
    logic [7:0] int_mask;
    logic [3:0] next_acc;
    logic next_zero_flag;
    logic next_carry_flag;
    logic [7:0] next_hold_mask;
    logic [7:0] next_int_mask;

    always_comb begin
        next_acc = acc;
        next_zero_flag = zero_flag;
        next_carry_flag = carry_flag;
        next_hold_mask = hold_mask;
        next_int_mask = int_mask;
        unique case (dif.op)
            FMM_NOP: begin
            end
            FMM_LD_ACC: begin
                next_acc = mem_rdata_i; // [RULE1]
                next_zero_flag = (mem_rdata_i == 4'h0); // [RULE1]
            end
            FMM_LD_CF: begin
                next_carry_flag = mem_rdata_i[0]; // [RULE2]
            end
            FMM_LD_HOLD: begin
                // Reserved bit forced low so it can never gate anything
                next_hold_mask = dif.imm & MASK_VALID; // [RULE3] [RULE11]
            end
            FMM_LD_INT: begin
                next_int_mask = dif.imm & MASK_VALID; // [RULE7] [RULE11]
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc <= ACC_RESET;
            zero_flag <= 1'b1;
            carry_flag <= 1'b0;
            hold_mask <= MASK_RESET;
            int_mask <= MASK_RESET;
        end else begin
            acc <= next_acc;
            zero_flag <= next_zero_flag;
            carry_flag <= next_carry_flag;
            hold_mask <= next_hold_mask;
            int_mask <= next_int_mask;
        end
    end

    // ****************************************
    // Event gating
    // ****************************************
    logic [7:0] hold_hits;
    logic [7:0] irq_hits;

    always_comb begin
        hold_hits = event_i & hold_mask & MASK_VALID; // [RULE11]
        irq_hits = event_i & int_mask & MASK_VALID; // [RULE11]
        hold_hits[BIT_RSVD] = 1'b0; // [RULE11]
        irq_hits[BIT_RSVD] = 1'b0; // [RULE11]
    end

    // Registered so outputs are glitch free; adds one cycle of latency
    logic hold_release;
    logic [7:0] irq_accept;
    logic next_hold_release;
    logic [7:0] next_irq_accept;

    always_comb begin
        next_hold_release = hold_hits[BIT_DIV0] | hold_hits[BIT_TMR0]
            | hold_hits[BIT_TMR1]; // [RULE4]
        next_hold_release = next_hold_release | hold_hits[BIT_CHG]
            | hold_hits[BIT_EXT]; // [RULE5]
        next_hold_release = next_hold_release | hold_hits[BIT_RX]
            | hold_hits[BIT_TX]; // [RULE6]
        next_irq_accept = irq_hits; // [RULE8] [RULE9] [RULE10]
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_release <= 1'b0;
            irq_accept <= MASK_RESET;
        end else begin
            hold_release <= next_hold_release;
            irq_accept <= next_irq_accept;
        end
    end

    assign acc_o = acc;
    assign zero_flag_o = zero_flag;
    assign carry_flag_o = carry_flag;
    assign hold_release_enable_mask_o = hold_mask;
    assign interrupt_enable_mask_o = int_mask;
    assign hold_release_o = hold_release;
    assign irq_accept_o = irq_accept;
endmodule

// ===== testbench/fmm_core_monitor.sv
// Checker: port-level assertions for the move and mask core
`timescale 1ns/1ns
module fmm_core_monitor
    import fmm_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [3:0] mem_rdata_i,
    input wire logic [7:0] event_i,
    // Outputs
    input wire logic [6:0] mem_addr_o,
    input wire logic [3:0] acc_o,
    input wire logic zero_flag_o,
    input wire logic carry_flag_o,
    input wire logic [7:0] hold_release_enable_mask_o,
    input wire logic [7:0] interrupt_enable_mask_o,
    input wire logic hold_release_o,
    input wire logic [7:0] irq_accept_o
);
    logic [7:0] hm;
    logic [7:0] im;
    assign hm = hold_release_enable_mask_o;
    assign im = interrupt_enable_mask_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_acc_load: assert property (instr_valid_i && instr_i[15:7] == OP_LD_ACC
        |=> acc_o == $past(mem_rdata_i) && zero_flag_o ==
        ($past(mem_rdata_i) == 4'h0)) else $error("acc load wrong");
    a_carry_load: assert property (instr_valid_i && instr_i[15:7] == OP_LD_CF
        |=> carry_flag_o == $past(mem_rdata_i[0]) && $stable(acc_o)
        && $stable(zero_flag_o)) else $error("carry load wrong");
    a_hold_load: assert property (instr_valid_i && instr_i[15:8] == OP_LD_HOLD
        |=> hm == ($past(instr_i[7:0]) & MASK_VALID))
        else $error("hold mask load wrong");
    a_int_load: assert property (instr_valid_i && instr_i[15:8] == OP_LD_INT
        |=> im == ($past(instr_i[7:0]) & MASK_VALID))
        else $error("int mask load wrong");
    // Mask of the event's own cycle gates it, not the updated one
    a_hold_gate: assert property (hold_release_o ==
        |($past(event_i) & $past(hm))) else $error("hold gate");
    a_irq_gate: assert property (irq_accept_o ==
        ($past(event_i) & $past(im))) else $error("irq gate");
    a_rsvd_zero: assert property (!hm[3] && !im[3] && !irq_accept_o[3])
        else $error("reserved bit live");
    a_addr_pass: assert property (mem_addr_o == instr_i[6:0])
        else $error("address field");
    a_idle_hold: assert property (!instr_valid_i |=> $stable(acc_o)
        && $stable(carry_flag_o) && $stable(hm) && $stable(im))
        else $error("state moved when idle");
endmodule

// ===== testbench/tb_top.sv
// Testbench: scoreboard bench for the move and mask core
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    import fmm_pkg::*;
    logic clk_i = 0;
    logic rstn_i = 0;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 0;
    logic [3:0] mem_rdata_i = 4'h0;
    logic [7:0] event_i = 8'h00;
    logic [6:0] mem_addr_o;
    logic [3:0] acc_o;
    logic zero_flag_o;
    logic carry_flag_o;
    logic hold_release_o;
    logic [7:0] hm_o;
    logic [7:0] im_o;
    logic [7:0] irq_o;
    logic [3:0] m_acc = 4'h0;
    logic m_z = 1;
    logic m_c = 0;
    logic [7:0] m_hm = 8'h00;
    logic [7:0] m_im = 8'h00;
    logic [30:0] q[$];
    logic [30:0] exp_v;
    logic [31:0] r;
    logic [15:0] ins;
    integer seed = 87;
    int k;
    int err_total = 0;
    int compares = 0;
    fmm_core i_fmm_core (.clk_i(clk_i), .rstn_i(rstn_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .mem_addr_o(mem_addr_o),
        .mem_rdata_i(mem_rdata_i), .event_i(event_i), .acc_o(acc_o),
        .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o),
        .hold_release_enable_mask_o(hm_o), .interrupt_enable_mask_o(im_o),
        .hold_release_o(hold_release_o), .irq_accept_o(irq_o));
    initial forever #4 clk_i = ~clk_i;
    task finish_test;
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****
    // Driver: one instruction a cycle, note of the state after its edge
    // ****
    task automatic exec(input logic v, input logic [15:0] i,
        input logic [3:0] rd, input logic [7:0] ev);
        logic hr;
        logic [7:0] irq;
        instr_valid_i = v;
        instr_i = i;
        mem_rdata_i = rd;
        event_i = ev;
        @(posedge clk_i);
        hr = |(ev & m_hm);
        irq = ev & m_im;
        if (v && i[15:7] == OP_LD_ACC) begin
            m_acc = rd;
            m_z = (rd == 4'h0);
        end else if (v && i[15:7] == OP_LD_CF) begin
            m_c = rd[0];
        end else if (v && i[15:8] == OP_LD_HOLD) begin
            m_hm = i[7:0] & MASK_VALID;
        end else if (v && i[15:8] == OP_LD_INT) begin
            m_im = i[7:0] & MASK_VALID;
        end
        #1;
        q.push_back({m_acc, m_z, m_c, m_hm, m_im, hr, irq});
    endtask
    always @(negedge clk_i) begin
        if (q.size() > 0) begin
            exp_v = q.pop_front();
            `CHK({acc_o, zero_flag_o, carry_flag_o, hm_o, im_o, hold_release_o, irq_o}, exp_v)
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        #1 rstn_i = 1;
        exec(0, {OP_LD_ACC, 7'h05}, 4'h5, 8'hff);
        exec(1, {OP_LD_HOLD, 8'hff}, 4'h0, 8'hff);
        exec(1, {OP_LD_INT, 8'hff}, 4'h0, 8'hff);
        exec(1, {OP_LD_ACC, 7'h05}, 4'h0, 8'h08);
        for (int b = 0; b < 8; b++) exec(1, {OP_LD_CF, 7'h11}, 4'h7, 8'h01 << b);
        // Random mix keeps masks changing under live events
        for (int n = 0; n < 300; n++) begin
            r = $random(seed);
            k = {$random(seed)} % 5;
            ins = (k == 0) ? {OP_LD_ACC, r[6:0]} : (k == 1) ? {OP_LD_CF, r[6:0]}
                : (k == 2) ? {OP_LD_HOLD, r[7:0]} : (k == 3) ? {OP_LD_INT, r[7:0]}
                : r[15:0];
            exec(r[16] | r[17], ins, r[21:18], r[29:22]);
        end
        @(posedge clk_i);
        #1 rstn_i = 0;
        {m_acc, m_z, m_c, m_hm, m_im} = {4'h0, 1'b1, 1'b0, 8'h00, 8'h00};
        repeat (2) @(posedge clk_i);
        #1 rstn_i = 1;
        exec(0, 16'h0000, 4'h3, 8'hff);
        exec(1, {OP_LD_INT, 8'h22}, 4'h3, 8'h00);
        exec(1, {OP_LD_ACC, 7'h7f}, 4'h9, 8'h22);
        finish_test;
    end
    initial begin
        #20000;
        err_total++;
        finish_test;
    end
endmodule
bind fmm_core fmm_core_monitor i_fmm_core_monitor (.clk_i(clk_i),
    .rstn_i(rstn_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .mem_rdata_i(mem_rdata_i), .event_i(event_i), .mem_addr_o(mem_addr_o),
    .acc_o(acc_o), .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o),
    .hold_release_enable_mask_o(hold_release_enable_mask_o),
    .interrupt_enable_mask_o(interrupt_enable_mask_o),
    .hold_release_o(hold_release_o), .irq_accept_o(irq_accept_o));
